// file: rtl/irq_vec_pkg.sv
// Constants for the interrupt vectoring and sleep control block.
package irq_vec_pkg;
    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_SYS_EN = 4'h0;
    localparam logic [3:0] ADDR_SER0_EN = 4'h1;
    localparam logic [3:0] ADDR_SYS_FLAGS = 4'h2;
    localparam logic [3:0] ADDR_SER0_FLAGS = 4'h3;
    localparam logic [3:0] ADDR_SLEEP = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_WDT_MODE = 4'h6;
    // System enable bit positions.
    localparam int EN_WDT = 0;
    localparam int EN_OSC = 1;
    localparam int EN_NMI = 4;
    localparam int EN_FLASH = 5;
    // System flag bit positions.
    localparam int FL_WDT = 0;
    localparam int FL_OSC = 1;
    localparam int FL_POR = 2;
    localparam int FL_RST = 3;
    localparam int FL_NMI = 4;
    // Implemented bit masks; unassigned positions do not exist.
    localparam logic [7:0] SYS_EN_MASK = 8'h33;
    localparam logic [7:0] SYS_FL_MASK = 8'h1f;
    localparam logic [7:0] SER0_MASK = 8'h0f;
    localparam logic [7:0] POR_FLAGS = 8'h04;
    // Vector word addresses.
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_NMI = 16'hfffc;
    localparam logic [15:0] VEC_LOW = 16'hffc0;
    localparam logic [15:0] VEC_FREE_TOP = 16'hffde;
    localparam logic [15:0] LOADER_KEY_ADDR = 16'hffde;
    localparam logic [15:0] LOADER_OFF_KEY = 16'haa55;
    localparam logic [15:0] BLANK_WORD = 16'hffff;
    localparam logic [15:0] PERIPH_TOP = 16'h01ff;
    // Unused hole between RAM and boot memory; a fetch there resets.
    localparam logic [15:0] HOLE_LO = 16'h0a00;
    localparam logic [15:0] HOLE_END = 16'h0c00;
    // Priority numbers of the two fixed top sources and of the lowest maskable slot.
    localparam logic [4:0] PRI_RESET = 5'h1f;
    localparam logic [4:0] PRI_NMI = 5'h1e;
    localparam logic [4:0] PRI_MASKABLE_LOW = 5'h10;
    // Sleep level encodings in the sleep register.
    localparam logic [2:0] SLEEP_NONE = 3'h0;
    localparam logic [2:0] SLEEP_L0 = 3'h1;
    localparam logic [2:0] SLEEP_L1 = 3'h2;
    localparam logic [2:0] SLEEP_L2 = 3'h3;
    localparam logic [2:0] SLEEP_L3 = 3'h4;
    localparam logic [2:0] SLEEP_L4 = 3'h5;
    // Vector address for a priority slot 16..29.
    function automatic logic [15:0] vec_of(input logic [4:0] pri);
        vec_of = VEC_LOW + {10'h0, pri, 1'b0};
    endfunction : vec_of
endpackage : irq_vec_pkg

// file: rtl/irq_prio_pick.sv
// Fixed priority picker over the maskable request lines.
`timescale 1ns/100ps
module irq_prio_pick
    import irq_vec_pkg::*;
#(
    parameter int N = 14
) (
    // Requests, bit i is priority 16+i
    input wire logic [N-1:0] req,
    // Result
    output logic any,
    output logic [4:0] pri
);
    initial begin
        if (N < 1 || N > 14) $error("irq_prio_pick: N out of range");
    end

    // Scan upward so the highest set bit wins.
    always_comb begin
        any = 1'b0;
        pri = PRI_MASKABLE_LOW;
        for (int i = 0; i < N; i++) begin
            if (req[i]) begin
                any = 1'b1;
                pri = PRI_MASKABLE_LOW + 5'(i);
            end
        end
    end
endmodule : irq_prio_pick

// file: rtl/irq_vec_ctrl.sv
// Interrupt vectoring, reset sourcing and sleep control for the core.
// What this block does
// - Reset vector 0xFFFE, priority 31, shared by all reset causes.
// - Vectors occupy 0xFFFF down to 0xFFC0, each a 16-bit handler address.
// - Blank reset vector after power-up sends device into deepest sleep.
// - Pin NMI, oscillator fault, flash violation share 0xFFFC, priority 30.
// - Non-maskable group gated only by its own enables, not global enable.
// - Seven-channel timer: channel 0 at 0xFFFA, others at 0xFFF8.
// - Comparator 0xFFF6, watchdog 0xFFF4, three-channel timer 0xFFF2/0xFFF0.
// - Serial A0/B0 receive share 0xFFEE, transmit share 0xFFEC.
// - Converter 0xFFEA, 0xFFE8 unused, port 2 0xFFE6, port 1 0xFFE4.
// - Serial A1/B1 receive 0xFFE2 priority 17, transmit 0xFFE0 priority 16.
// - Slots 0xFFDE to 0xFFC0 unused, treated as ordinary code memory.
// - Key word 0xAA55 disables loader; zero blocks erase on bad password.
// - Fetch from 0x0000-0x01FF or unused ranges causes a reset.
// - Two-wire mode: B0 status on receive vector, data flags on transmit.
// - Watchdog enable works only in interval timer mode.
// - Watchdog flag set on overflow or key violation, cleared on power-on/pin reset.
// - Power-on, pin reset and pin NMI flags set by their causes.
// - Unassigned register bits are not implemented and read zero.
// - Sleep 0 stops CPU and main clock, auxiliary and sub-main run.
// - Sleep 1 also drops bias if unused; sleep 2 stops sub-main, keeps bias.
// - Sleep 3 stops bias too; sleep 4 also stops auxiliary clock and crystal.
// - Enabled interrupt wakes any sleep; return restores previous sleep level.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module irq_vec_ctrl
    import irq_vec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Reset and non-maskable causes, one-cycle pulses except flash_violation, which is a level
    input wire logic power_up,
    input wire logic pin_reset,
    input wire logic pin_nmi,
    input wire logic osc_fault,
    input wire logic flash_violation,
    input wire logic flash_key_violation,
    input wire logic watchdog_overflow,
    // Maskable request levels from peripherals
    input wire logic timer7_ch0_req,
    input wire logic timer7_other_req,
    input wire logic comparator_flag,
    input wire logic timer3_ch0_req,
    input wire logic timer3_other_req,
    input wire logic ser_b0_status_req,
    input wire logic i2c_mode,
    input wire logic converter_flag,
    input wire logic [7:0] port2_pin_flags,
    input wire logic [7:0] port1_pin_flags,
    input wire logic ser_a1_rx_flag,
    input wire logic ser_b1_rx_flag,
    input wire logic ser_a1_tx_flag,
    input wire logic ser_b1_tx_flag,
    // Core side
    input wire logic gie,
    input wire logic irq_ack,
    input wire logic irq_return,
    input wire logic [15:0] fetch_addr,
    input wire logic fetch_valid,
    input wire logic [15:0] reset_vector_word,
    input wire logic [15:0] loader_key_word,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic [4:0] irq_priority,
    output logic soft_clear,
    // Clock and power gating, loader key decode
    output logic cpu_off,
    output logic main_clk_off,
    output logic submain_clock_off,
    output logic aux_clk_off,
    output logic osc_bias_off,
    output logic crystal_off,
    output logic loader_disabled,
    output logic erase_on_bad_pw_blocked
);
    localparam int NMASK = 14;

    typedef struct packed {
        logic [7:0] sys_en;
        logic [7:0] ser0_en;
        logic [7:0] sys_flags;
        logic [7:0] ser0_flags;
        logic [2:0] sleep;
        logic [2:0] saved_sleep;
        logic in_handler;
        logic wdt_interval;
        logic osc_used;
        logic por_check;
        logic soft_clear;
        logic [7:0] rdata;
        logic irq_req;
        logic [15:0] vector;
        logic [4:0] prio;
    } state_t;

    state_t cur;
    state_t next_s;
    logic [NMASK-1:0] mreq;
    logic m_any;
    logic [4:0] m_pri;
    logic nmi_pend;
    logic [7:0] ser0_raw;

    // Two-wire routing.
    // In two-wire mode the B0 receive flag carries bus status events and its
    // transmit slot also carries received data.
    assign ser0_raw = cur.ser0_flags & cur.ser0_en;

    // Priority ordering.
    // Slot bit i maps to priority 16+i; bit 4 (priority 20) is never driven.
    always_comb begin
        mreq = '0;
        mreq[0] = ser_a1_tx_flag | ser_b1_tx_flag;
        mreq[1] = ser_a1_rx_flag | ser_b1_rx_flag;
        mreq[2] = |port1_pin_flags;
        mreq[3] = |port2_pin_flags;
        mreq[5] = converter_flag;
        mreq[6] = ser0_raw[1] | ser0_raw[3] | (i2c_mode & ser0_raw[2]);
        mreq[7] = ser0_raw[0] | (i2c_mode ? ser_b0_status_req : ser0_raw[2]);
        mreq[8] = timer3_other_req;
        mreq[9] = timer3_ch0_req;
        mreq[10] = cur.wdt_interval & cur.sys_en[EN_WDT] & cur.sys_flags[FL_WDT];
        mreq[11] = comparator_flag;
        mreq[12] = timer7_other_req;
        mreq[13] = timer7_ch0_req;
        mreq = gie ? mreq : '0;
    end

    irq_prio_pick #(.N(NMASK)) u_pick (
        .req(mreq),
        .any(m_any),
        .pri(m_pri)
    );

    assign nmi_pend = (cur.sys_flags[FL_NMI] & cur.sys_en[EN_NMI])
                    | (cur.sys_flags[FL_OSC] & cur.sys_en[EN_OSC])
                    | (flash_violation & cur.sys_en[EN_FLASH]);

    // Next-state logic for all registers of the block.
    always_comb begin
        next_s = cur;
        next_s.soft_clear = 1'b0;
        next_s.rdata = '0;
        next_s.por_check = 1'b0;
        // Register reads, unmapped addresses return zero.
        if (reg_rd) begin
            if (reg_addr == ADDR_SYS_EN) begin
                next_s.rdata = cur.sys_en;
            end else if (reg_addr == ADDR_SER0_EN) begin
                next_s.rdata = cur.ser0_en;
            end else if (reg_addr == ADDR_SYS_FLAGS) begin
                next_s.rdata = cur.sys_flags;
            end else if (reg_addr == ADDR_SER0_FLAGS) begin
                next_s.rdata = cur.ser0_flags;
            end else if (reg_addr == ADDR_SLEEP) begin
                next_s.rdata = {5'h0, cur.sleep};
            end else if (reg_addr == ADDR_STATUS) begin
                next_s.rdata = {2'h0, cur.saved_sleep, cur.in_handler, nmi_pend, m_any};
            end else if (reg_addr == ADDR_WDT_MODE) begin
                next_s.rdata = {6'h0, cur.osc_used, cur.wdt_interval};
            end
        end
        // Register writes; unassigned bits are masked away.
        if (reg_wr) begin
            if (reg_addr == ADDR_SYS_EN) begin
                next_s.sys_en = reg_wdata & SYS_EN_MASK;
            end else if (reg_addr == ADDR_SER0_EN) begin
                next_s.ser0_en = reg_wdata & SER0_MASK;
            end else if (reg_addr == ADDR_SYS_FLAGS) begin
                next_s.sys_flags = reg_wdata & SYS_FL_MASK;
            end else if (reg_addr == ADDR_SER0_FLAGS) begin
                next_s.ser0_flags = reg_wdata & SER0_MASK;
            end else if (reg_addr == ADDR_SLEEP) begin
                next_s.sleep = (reg_wdata[2:0] > SLEEP_L4) ? SLEEP_L4 : reg_wdata[2:0];
            end else if (reg_addr == ADDR_WDT_MODE) begin
                next_s.wdt_interval = reg_wdata[0];
                next_s.osc_used = reg_wdata[1];
            end
        end
        // Watchdog flag; the set wins over a software clear.
        if (pin_reset) begin
            next_s.sys_flags[FL_WDT] = 1'b0;
        end
        if (watchdog_overflow | flash_key_violation) begin
            next_s.sys_flags[FL_WDT] = 1'b1;
        end
        // Cause flags set by their events.
        if (pin_reset) begin
            next_s.sys_flags[FL_RST] = 1'b1;
        end
        if (pin_nmi) begin
            next_s.sys_flags[FL_NMI] = 1'b1;
        end
        if (osc_fault) begin
            next_s.sys_flags[FL_OSC] = 1'b1;
        end
        // Two-wire status latches the B0 receive flag.
        if (i2c_mode & ser_b0_status_req) begin
            next_s.ser0_flags[2] = 1'b1;
        end
        // Fetch outside code space forces a soft clear.
        if (fetch_valid && (fetch_addr <= PERIPH_TOP
                || (fetch_addr >= HOLE_LO && fetch_addr < HOLE_END))) begin
            next_s.soft_clear = 1'b1;
        end
        // Reset sources all funnel to the reset vector.
        if (pin_reset | flash_key_violation | next_s.soft_clear
                | (watchdog_overflow & ~cur.wdt_interval)) begin
            next_s.soft_clear = 1'b1;
            next_s.sleep = SLEEP_NONE;
            next_s.in_handler = 1'b0;
            next_s.sys_en = '0;
            next_s.ser0_en = '0;
        end
        // Power-up reset, then a blank check.
        if (power_up) begin
            next_s.sys_flags = POR_FLAGS;
            next_s.soft_clear = 1'b1;
            next_s.por_check = 1'b1;
            next_s.sleep = SLEEP_NONE;
        end
        // Blank reset vector goes to deepest sleep.
        if (cur.por_check && reset_vector_word == BLANK_WORD) begin
            next_s.sleep = SLEEP_L4;
        end
        // Vector selection, non-maskable group beats all maskable ones.
        next_s.irq_req = 1'b0;
        // A reset entry stays requested until the core takes it, so none is lost.
        if (cur.soft_clear || (cur.irq_req && cur.prio == PRI_RESET)) begin
            next_s.irq_req = 1'b1;
            next_s.vector = VEC_RESET;
            next_s.prio = PRI_RESET;
        end else if (nmi_pend) begin
            next_s.irq_req = 1'b1;
            next_s.vector = VEC_NMI;
            next_s.prio = PRI_NMI;
        end else if (m_any) begin
            next_s.irq_req = 1'b1;
            next_s.vector = vec_of(m_pri);
            next_s.prio = m_pri;
        end
        // Wake on grant, restore level on return.
        if (irq_ack & cur.irq_req) begin
            next_s.saved_sleep = cur.sleep;
            next_s.sleep = SLEEP_NONE;
            next_s.in_handler = 1'b1;
            next_s.irq_req = 1'b0;
            if (cur.prio == PRI_NMI && !pin_nmi) begin
                next_s.sys_flags[FL_NMI] = 1'b0;
            end
        end else if (irq_return & cur.in_handler) begin
            next_s.sleep = cur.saved_sleep;
            next_s.in_handler = 1'b0;
        end
    end

    // Single state register, cleared to run state with power-on flag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{sys_flags: POR_FLAGS, default: '0};
        end else begin
            cur <= next_s;
        end
    end

    assign reg_rdata = cur.rdata;
    assign irq_req = cur.irq_req;
    assign irq_vector = cur.vector;
    assign irq_priority = cur.prio;
    assign soft_clear = cur.soft_clear;

    assign cpu_off = (cur.sleep != SLEEP_NONE);
    assign main_clk_off = (cur.sleep != SLEEP_NONE);
    assign submain_clock_off = (cur.sleep >= SLEEP_L2);
    assign aux_clk_off = (cur.sleep == SLEEP_L4);
    assign crystal_off = (cur.sleep == SLEEP_L4);
    assign osc_bias_off = (cur.sleep >= SLEEP_L3)
                        || (cur.sleep == SLEEP_L1 && !cur.osc_used);

    // Slots below 0xFFE0 carry no vectors, so the key word is plain memory.
    assign loader_disabled = (loader_key_word == LOADER_OFF_KEY);
    assign erase_on_bad_pw_blocked = ~|loader_key_word;

    // Assertions.
    property p_reset_vec;
        @(posedge clk) disable iff (!rst_n) cur.soft_clear |=> irq_req && irq_vector == VEC_RESET
            && irq_priority == PRI_RESET;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");
    property p_vec_range;
        @(posedge clk) disable iff (!rst_n) irq_req |-> irq_vector >= vec_of(PRI_MASKABLE_LOW);
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector out of range");
    property p_blank;
        @(posedge clk) disable iff (!rst_n) power_up ##1 (reset_vector_word == BLANK_WORD)
            |=> cur.sleep == SLEEP_L4;
    endproperty
    a_blank: assert property (p_blank) else $error("blank vector not sleeping");
    property p_nmi;
        @(posedge clk) disable iff (!rst_n) (!cur.soft_clear && nmi_pend
            && !(irq_req && irq_priority == PRI_RESET)) |=> irq_vector == VEC_NMI;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi vector wrong");
    property p_nmi_gie;
        @(posedge clk) disable iff (!rst_n) (!gie && !cur.soft_clear && !nmi_pend
            && !(irq_req && irq_priority == PRI_RESET)) |=> !irq_req;
    endproperty
    a_nmi_gie: assert property (p_nmi_gie) else $error("maskable passed gie");
    property p_wdt_mode;
        @(posedge clk) disable iff (!rst_n) !cur.wdt_interval |-> !mreq[10];
    endproperty
    a_wdt_mode: assert property (p_wdt_mode) else $error("watchdog irq in reset mode");
    property p_sleep4;
        @(posedge clk) disable iff (!rst_n) cur.sleep == SLEEP_L4 |-> aux_clk_off && crystal_off
            && osc_bias_off && submain_clock_off;
    endproperty
    a_sleep4: assert property (p_sleep4) else $error("sleep 4 clocks wrong");
    property p_restore;
        @(posedge clk) disable iff (!rst_n) (irq_return && cur.in_handler
            && !(irq_ack && irq_req)) |=> cur.sleep == $past(cur.saved_sleep);
    endproperty
    a_restore: assert property (p_restore) else $error("sleep not restored");
    property p_fetch;
        @(posedge clk) disable iff (!rst_n) (fetch_valid && fetch_addr <= PERIPH_TOP)
            |=> soft_clear;
    endproperty
    a_fetch: assert property (p_fetch) else $error("bad fetch no reset");
    c_nmi: cover property (@(posedge clk) disable iff (!rst_n) irq_req && irq_vector == VEC_NMI);
    c_wake: cover property (@(posedge clk) disable iff (!rst_n) cpu_off && irq_ack);
    c_mask: cover property (@(posedge clk) disable iff (!rst_n) irq_req && irq_priority < 5'h1e);
endmodule : irq_vec_ctrl

// file: tb/core_model.sv
// Processor core model: takes interrupts, runs handlers, returns.
`timescale 1ns/100ps
module core_model
    import irq_vec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench settings: global enable, answer at all, answer delay
    input wire logic gie_en,
    input wire logic auto_en,
    input wire logic [3:0] ack_wait,
    // Block side
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic soft_clear,
    output logic gie,
    output logic irq_ack,
    output logic irq_return
);
    localparam logic [3:0] RET_WAIT = 4'h8;
    logic busy;
    logic [3:0] cnt;
    // A core clears its own global enable while a handler runs.
    assign gie = gie_en && !busy;
    // Grant after ack_wait cycles; a reset entry never returns.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
        end else begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            cnt <= 4'h0;
            if (soft_clear) begin
                busy <= 1'b0;
            end else if (busy) begin
                cnt <= cnt + 4'h1;
                if (cnt == RET_WAIT) begin
                    irq_return <= 1'b1;
                    busy <= 1'b0;
                    cnt <= 4'h0;
                end
            end else if (irq_req && auto_en) begin
                cnt <= cnt + 4'h1;
                if (cnt == ack_wait) begin
                    irq_ack <= 1'b1;
                    busy <= (irq_vector != VEC_RESET);
                    cnt <= 4'h0;
                end
            end
        end
    end
endmodule : core_model

// file: tb/irq_vec_ctrl_tb.sv
// Self-checking bench for the interrupt vectoring and sleep control block.
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module irq_vec_ctrl_tb
    import irq_vec_pkg::*;
;
    typedef struct packed {
        logic [13:0] sel;
        logic [3:0] s0f;
        logic i2c;
        logic [15:0] vec;
    } row_t;
    // Rows: requests, serial flags, two-wire mode, vector.
    localparam row_t ROWS [19] = '{
        '{14'h0001, 4'h0, 1'b0, 16'hffe0}, '{14'h0002, 4'h0, 1'b0, 16'hffe0},
        '{14'h0004, 4'h0, 1'b0, 16'hffe2}, '{14'h0008, 4'h0, 1'b0, 16'hffe2},
        '{14'h0010, 4'h0, 1'b0, 16'hffe4}, '{14'h0020, 4'h0, 1'b0, 16'hffe4},
        '{14'h0040, 4'h0, 1'b0, 16'hffe6}, '{14'h0080, 4'h0, 1'b0, 16'hffea},
        '{14'h0100, 4'h0, 1'b0, 16'hfff0}, '{14'h0200, 4'h0, 1'b0, 16'hfff2},
        '{14'h0400, 4'h0, 1'b0, 16'hfff6}, '{14'h0800, 4'h0, 1'b0, 16'hfff8},
        '{14'h1000, 4'h0, 1'b0, 16'hfffa}, '{14'h2000, 4'h0, 1'b1, 16'hffee},
        '{14'h0000, 4'h1, 1'b0, 16'hffee}, '{14'h0000, 4'h2, 1'b0, 16'hffec},
        '{14'h0000, 4'h4, 1'b0, 16'hffee}, '{14'h0000, 4'h4, 1'b1, 16'hffec},
        '{14'h0000, 4'h8, 1'b0, 16'hffec}};
    localparam logic [7:0] NMI_EN [3] = '{8'h10, 8'h02, 8'h20};
    localparam logic [7:0] NMI_FL [3] = '{8'h10, 8'h02, 8'h00};
    localparam int RST_IDX [3] = '{5, 1, 0};
    localparam logic [7:0] RST_FL [3] = '{8'h01, 8'h08, 8'h04};
    localparam logic [15:0] F_ADDR [4] = '{16'h0000, 16'h01ff, 16'h0200, 16'h0a00};
    localparam logic F_RST [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    localparam logic [5:0] SLP [6] = '{6'h00, 6'h30, 6'h32, 6'h38, 6'h3a, 6'h3f};
    localparam logic [15:0] KEYS [3] = '{16'haa55, 16'h0000, 16'h1234};
    localparam logic [1:0] KEY_EXP [3] = '{2'b10, 2'b01, 2'b00};
    logic clk, rst_n, reg_wr, reg_rd, i2c_mode, fetch_valid, gie, irq_ack, irq_return;
    logic gie_en, auto_en, irq_req, soft_clear, cpu_off, main_clk_off, submain_clock_off;
    logic aux_clk_off, osc_bias_off, crystal_off, loader_disabled, erase_on_bad_pw_blocked;
    logic [3:0] reg_addr, ack_wait;
    logic [7:0] reg_wdata, reg_rdata;
    logic [6:0] cause;
    logic [13:0] req_sel;
    logic [15:0] fetch_addr, reset_vector_word, loader_key_word, irq_vector;
    logic [4:0] irq_priority;
    logic [5:0] outs;
    int mismatches, n_compared, n_sc, sc_mark;
    assign outs = {cpu_off, main_clk_off, submain_clock_off, aux_clk_off, osc_bias_off,
        crystal_off};
    // Free-running 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Count soft clear pulses.
    always @(posedge clk) if (soft_clear === 1'b1) n_sc++;
    irq_vec_ctrl uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .power_up(cause[0]),
        .pin_reset(cause[1]), .pin_nmi(cause[2]), .osc_fault(cause[3]),
        .flash_violation(cause[4]), .flash_key_violation(cause[5]),
        .watchdog_overflow(cause[6]), .ser_a1_tx_flag(req_sel[0]), .ser_b1_tx_flag(req_sel[1]),
        .ser_a1_rx_flag(req_sel[2]), .ser_b1_rx_flag(req_sel[3]),
        .port1_pin_flags({req_sel[5], 6'h00, req_sel[4]}),
        .port2_pin_flags({4'h0, req_sel[6], 3'h0}), .converter_flag(req_sel[7]),
        .timer3_other_req(req_sel[8]), .timer3_ch0_req(req_sel[9]),
        .comparator_flag(req_sel[10]), .timer7_other_req(req_sel[11]),
        .timer7_ch0_req(req_sel[12]), .ser_b0_status_req(req_sel[13]), .i2c_mode, .gie,
        .irq_ack, .irq_return, .fetch_addr, .fetch_valid, .reset_vector_word,
        .loader_key_word, .irq_req, .irq_vector, .irq_priority, .soft_clear, .cpu_off,
        .main_clk_off, .submain_clock_off, .aux_clk_off, .osc_bias_off, .crystal_off,
        .loader_disabled, .erase_on_bad_pw_blocked);
    core_model core (.clk, .rst_n, .gie_en, .auto_en, .ack_wait, .irq_req, .irq_vector,
        .soft_clear, .gie, .irq_ack, .irq_return);
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    // One idle cycle follows each strobe.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick();
        reg_wr <= 1'b0;
        tick();
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick();
        `CHK(reg_rdata & m, e)
        reg_rd <= 1'b0;
        tick();
    endtask : rd
    task automatic pulse(input int i);
        cause <= 7'h01 << i;
        tick();
        cause <= 7'h00;
        tick();
    endtask : pulse
    // Bounded wait: 0 request, 1 grant, 2 return, 3 soft clear since the mark.
    task automatic wait_for(input int w);
        int i;
        logic s;
        for (i = 0; i < 80; i++) begin
            s = (w == 0) ? irq_req : (w == 1) ? irq_ack : (w == 2) ? irq_return : n_sc != sc_mark;
            if (s === 1'b1) break;
            tick();
        end
        if (i == 80) begin
            mismatches++;
            test_done();
        end
    endtask : wait_for
    task automatic expect_irq(input logic [15:0] v);
        wait_for(0);
        `CHK(irq_vector, v)
        `CHK(irq_priority, v[5:1])
    endtask : expect_irq
    // Handler drops its sources before the core returns.
    task automatic retire(input logic [13:0] keep);
        wait_for(1);
        req_sel <= req_sel & keep;
        wr(ADDR_SER0_FLAGS, 8'h00);
        wr(ADDR_SYS_FLAGS, 8'h00);
        wait_for(2);
        tick();
    endtask : retire
    initial begin
        int k;
        {reg_wr, reg_rd, i2c_mode, fetch_valid, gie_en, cause, req_sel} = '0;
        {reg_addr, reg_wdata, fetch_addr, loader_key_word} = '0;
        {auto_en, ack_wait, reset_vector_word, rst_n} = {1'b1, 4'h1, 16'h4400, 1'b0};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        tick();
        rd(ADDR_SYS_FLAGS, 8'hff, POR_FLAGS);
        rd(4'hf, 8'hff, 8'h00);
        wr(ADDR_SYS_EN, 8'hff);
        rd(ADDR_SYS_EN, 8'hff, 8'h33);
        wr(ADDR_SER0_EN, 8'hff);
        rd(ADDR_SER0_EN, 8'hff, 8'h0f);
        wr(ADDR_SYS_EN, 8'h00);
        gie_en <= 1'b1;
        for (k = 0; k < 19; k++) begin
            i2c_mode <= ROWS[k].i2c;
            req_sel <= ROWS[k].sel;
            if (ROWS[k].s0f != 4'h0) wr(ADDR_SER0_FLAGS, {4'h0, ROWS[k].s0f});
            expect_irq(ROWS[k].vec);
            retire(14'h0);
        end
        gie_en <= 1'b0;
        req_sel <= 14'h0001;
        repeat (10) tick();
        `CHK(irq_req, 1'b0)
        gie_en <= 1'b1;
        ack_wait <= 4'h9;
        req_sel <= 14'h1011;
        expect_irq(16'hfffa);
        retire(14'h0011);
        expect_irq(16'hffe4);
        retire(14'h0001);
        expect_irq(16'hffe0);
        retire(14'h0);
        {ack_wait, gie_en} <= {4'h1, 1'b0};
        for (k = 0; k < 3; k++) begin
            wr(ADDR_SYS_EN, NMI_EN[k]);
            // The flash violation is a level, so every cause is held until the grant.
            cause <= 7'h04 << k;
            expect_irq(VEC_NMI);
            wait_for(1);
            cause <= 7'h00;
            retire(14'h0);
            wr(ADDR_SYS_EN, 8'h00);
            pulse(2 + k);
            repeat (6) tick();
            `CHK(irq_req, 1'b0)
            rd(ADDR_SYS_FLAGS, 8'h1f, NMI_FL[k]);
            wr(ADDR_SYS_FLAGS, 8'h00);
        end
        for (k = 0; k < 3; k++) begin
            sc_mark = n_sc;
            pulse(RST_IDX[k]);
            wait_for(3);
            expect_irq(VEC_RESET);
            wait_for(1);
            rd(ADDR_SYS_FLAGS, 8'h0d, RST_FL[k]);
        end
        for (k = 0; k < 4; k++) begin
            sc_mark = n_sc;
            {fetch_addr, fetch_valid} <= {F_ADDR[k], 1'b1};
            tick();
            fetch_valid <= 1'b0;
            repeat (4) tick();
            `CHK(n_sc != sc_mark, F_RST[k])
        end
        wr(ADDR_WDT_MODE, 8'h01);
        wr(ADDR_SYS_EN, 8'h01);
        gie_en <= 1'b1;
        sc_mark = n_sc;
        pulse(6);
        expect_irq(16'hfff4);
        retire(14'h0);
        `CHK(n_sc, sc_mark)
        wr(ADDR_WDT_MODE, 8'h00);
        wr(ADDR_SYS_EN, 8'h01);
        pulse(6);
        expect_irq(VEC_RESET);
        wait_for(1);
        for (k = 0; k < 6; k++) begin
            wr(ADDR_SLEEP, 8'(k));
            `CHK(outs, SLP[k])
        end
        wr(ADDR_WDT_MODE, 8'h02);
        wr(ADDR_SLEEP, {5'h0, SLEEP_L1});
        `CHK(outs, 6'h30)
        wr(ADDR_WDT_MODE, 8'h00);
        wr(ADDR_SLEEP, {5'h0, SLEEP_L3});
        gie_en <= 1'b1;
        req_sel <= 14'h0400;
        expect_irq(16'hfff6);
        wait_for(1);
        tick();
        `CHK(cpu_off, 1'b0)
        req_sel <= 14'h0;
        wait_for(2);
        repeat (2) tick();
        `CHK(outs, 6'h3a)
        wr(ADDR_SLEEP, 8'h00);
        {auto_en, reset_vector_word} <= {1'b0, BLANK_WORD};
        sc_mark = n_sc;
        pulse(0);
        wait_for(3);
        repeat (3) tick();
        `CHK(outs, 6'h3f)
        {auto_en, reset_vector_word} <= {1'b1, 16'h4400};
        for (k = 0; k < 3; k++) begin
            loader_key_word <= KEYS[k];
            tick();
            `CHK({loader_disabled, erase_on_bad_pw_blocked}, KEY_EXP[k])
        end
        test_done();
    end
endmodule : irq_vec_ctrl_tb
